// file: tsc_status_regs.sv
`timescale 1ns/1ns
// How it works
// - Control holds 8-bit transmit data delay.
// - Transmit clock rises at divider, falls half.
// - Ethernet ports connected only while enable set.
// - Dynamic divider applies only when threads paused.
// - Control bit enables low-power clock divider.
// - Control bit selects UTMI or ULPI transceiver.
// - Control bit enables ULPI support module.
// - Boot status read-only, reports processor number.
// - Boot status reports second core powered off.
// - Boot status reports skip OTP level polling.
// - Boot status reports RAM and JTAG boot.
// - Boot status returns sampled PLL strap pins.
// - Protection register loaded from OTP security word.
// - Lock bit refuses further protection writes.
// - Protection bit blocks global debug access.
// - Protection bits lock OTP sectors, enable redundancy.
// - Protection bit forces boot image from OTP.
// - Protection bits block PLL JTAG, debug TAP.
// - Four oscillator counters, two run control bits.
// - Oscillators run asynchronously to tile clock.
// - Counter registers return 16 bits, no reset.
// - Three further counter registers, same format.
module tsc_status_regs
#(
    parameter int CNT_W = tsc_pkg::OSC_COUNT_W
)
(
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        ps_write_i,
    input  wire logic        ps_read_i,
    input  wire logic [7:0]  ps_addr_i,
    input  wire logic [31:0] ps_wdata_i,
    output logic      [31:0] ps_rdata_o,
    output logic             ps_rvalid_o,
    input  wire logic        threads_paused_i,
    input  wire logic [7:0]  processor_number_i,
    input  wire logic        second_core_powered_flag_i,
    input  wire logic        skip_otp_level_poll_i,
    input  wire logic        boot_from_ram_i,
    input  wire logic        boot_from_jtag_i,
    input  wire logic [1:0]  pll_strap_value_i,
    input  wire logic        otp_load_i,
    input  wire logic [31:0] otp_security_word_i,
    input  wire logic [3:0]  osc_i,
    output logic             ethernet_port_enable_o,
    output logic             rgmii_tx_clk_o,
    output logic             rgmii_tx_launch_o,
    output logic             lp_div_active_o,
    output logic             usb_phy_interface_select_o,
    output logic             transceiver_support_enable_o,
    output logic             global_debug_block_o,
    output logic             otp_master_lock_o,
    output logic [3:0]       otp_sector_lock_o,
    output logic             otp_redundancy_en_o,
    output logic             otp_boot_override_o,
    output logic             pll_jtag_block_o,
    output logic             jtag_tap_block_o,
    output logic [3:0]       osc_run_o
);

    logic [31:0]      ctrl_r;
    logic [31:0]      prot_r;
    logic [1:0]       osc_ctrl_r;
    logic [1:0]       strap_s1_r;
    logic [1:0]       strap_s2_r;
    logic [1:0]       strap_s3_r;
    logic [1:0]       strap_r;
    logic [31:0]      rdata_nxt;
    logic [31:0]      boot_word;
    logic [CNT_W-1:0] osc_cnt_r [tsc_pkg::OSC_NUM] = '{default: '0};
    logic [3:0]       osc_run;

    logic wr_ctrl;
    logic wr_prot;
    logic wr_osc;

    assign wr_ctrl = ps_write_i && (ps_addr_i == tsc_pkg::REG_TILE_CTRL);
    assign wr_prot = ps_write_i && (ps_addr_i == tsc_pkg::REG_PROTECTION);
    assign wr_osc  = ps_write_i && (ps_addr_i == tsc_pkg::REG_OSC_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Register writes.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            ctrl_r <= tsc_pkg::CTRL_RESET;
        else if (wr_ctrl)
            ctrl_r <= ps_wdata_i & tsc_pkg::CTRL_WMASK;
    end

    // The OTP copy wins over a software write in the same cycle, since the
    // lock it may carry must never be dodged by a racing store.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            prot_r <= tsc_pkg::PROT_RESET;
        else if (otp_load_i)
            prot_r <= otp_security_word_i & tsc_pkg::PROT_WMASK;
        else if (wr_prot && !prot_r[tsc_pkg::PROT_LOCK_BIT])
            prot_r <= ps_wdata_i & tsc_pkg::PROT_WMASK;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            osc_ctrl_r <= tsc_pkg::OSC_RUN_RESET;
        else if (wr_osc)
            osc_ctrl_r <= ps_wdata_i[1:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strap pins are outside the clock domain.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            strap_s1_r <= '0;
            strap_s2_r <= '0;
            strap_s3_r <= '0;
            strap_r    <= '0;
        end
        else
        begin
            strap_s1_r <= pll_strap_value_i;
            strap_s2_r <= strap_s1_r;
            strap_s3_r <= strap_s2_r;
            if (strap_s2_r == strap_s3_r)
                strap_r <= strap_s3_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Derived outputs.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            lp_div_active_o <= 1'b0;
        else
            lp_div_active_o <= ctrl_r[tsc_pkg::LP_EN_BIT]
                && (!ctrl_r[tsc_pkg::LP_DYN_BIT] || threads_paused_i);
    end

    assign ethernet_port_enable_o       = ctrl_r[tsc_pkg::ETH_EN_BIT];
    assign usb_phy_interface_select_o   = ctrl_r[tsc_pkg::USB_SEL_BIT];
    assign transceiver_support_enable_o = ctrl_r[tsc_pkg::USB_SUP_BIT];
    assign global_debug_block_o         = prot_r[tsc_pkg::PROT_GDBG_BIT];
    assign otp_master_lock_o            = prot_r[tsc_pkg::PROT_MASTER_BIT];
    assign otp_sector_lock_o            = prot_r[tsc_pkg::PROT_SECTOR_LSB +: 4];
    assign otp_redundancy_en_o          = prot_r[tsc_pkg::PROT_REDUND_BIT];
    assign otp_boot_override_o          = prot_r[tsc_pkg::PROT_BOOT_OTP_BIT];
    assign pll_jtag_block_o             = prot_r[tsc_pkg::PROT_PLL_JTAG_BIT];
    assign jtag_tap_block_o             = prot_r[tsc_pkg::PROT_TAP_BIT];
    assign osc_run = {osc_ctrl_r[tsc_pkg::OSC_PERIPH_BIT], osc_ctrl_r[tsc_pkg::OSC_PERIPH_BIT],
                      osc_ctrl_r[tsc_pkg::OSC_CORE_BIT], osc_ctrl_r[tsc_pkg::OSC_CORE_BIT]};
    assign osc_run_o = osc_run;

    tsc_txclk_gen
    #(
        .DIV_W (tsc_pkg::TXCLK_DIV_W),
        .DLY_W (tsc_pkg::TXD_DLY_W)
    )
    u_txclk
    (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .enable_i    (ctrl_r[tsc_pkg::ETH_EN_BIT]),
        .div_i       (ctrl_r[tsc_pkg::TXCLK_DIV_LSB +: tsc_pkg::TXCLK_DIV_W]),
        .delay_i     (ctrl_r[tsc_pkg::TXD_DLY_LSB +: tsc_pkg::TXD_DLY_W]),
        .tx_clk_o    (rgmii_tx_clk_o),
        .tx_launch_o (rgmii_tx_launch_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator counters. Each oscillator output is sampled three deep and
    // a rising edge is counted while the second stage is high and the third is still low.
    // The counters carry no reset so their contents survive a system reset.
    // They start from zero at power-up only, so the first count is known.
    generate
        for (genvar g = 0; g < tsc_pkg::OSC_NUM; g++)
        begin : g_osc
            logic s1_r;
            logic s2_r;
            logic s3_r;

            always_ff @(posedge clk_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                end
                else
                begin
                    s1_r <= osc_i[g];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                end
            end

            always_ff @(posedge clk_i)
            begin
                if (osc_run[g] && s2_r && !s3_r)
                    osc_cnt_r[g] <= osc_cnt_r[g] + 1'b1;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read path: one-cycle latency; unmapped numbers read zero.
    always_comb
    begin
        boot_word = tsc_pkg::ZERO_WORD;
        boot_word[tsc_pkg::PROC_NUM_LSB +: 8]           = processor_number_i;
        boot_word[tsc_pkg::BOOT_OVERRIDE_BIT]           = prot_r[tsc_pkg::PROT_BOOT_OTP_BIT];
        boot_word[tsc_pkg::CORE_OFF_BIT]                = second_core_powered_flag_i;
        boot_word[tsc_pkg::SKIP_POLL_BIT]               = skip_otp_level_poll_i;
        boot_word[tsc_pkg::BOOT_RAM_BIT]                = boot_from_ram_i;
        boot_word[tsc_pkg::BOOT_JTAG_BIT]               = boot_from_jtag_i;
        boot_word[tsc_pkg::STRAP_LSB +: tsc_pkg::STRAP_W] = strap_r;
    end

    always_comb
    begin
        rdata_nxt = tsc_pkg::ZERO_WORD;
        if (ps_addr_i == tsc_pkg::REG_TILE_CTRL)
            rdata_nxt = ctrl_r;
        else if (ps_addr_i == tsc_pkg::REG_BOOT_STATUS)
            rdata_nxt = boot_word;
        else if (ps_addr_i == tsc_pkg::REG_PROTECTION)
            rdata_nxt = prot_r;
        else if (ps_addr_i == tsc_pkg::REG_OSC_RUN)
            rdata_nxt = {30'h0000_0000, osc_ctrl_r};
        else if (ps_addr_i >= tsc_pkg::REG_OSC_COUNT0
                 && ps_addr_i < tsc_pkg::REG_OSC_COUNT0 + 8'(tsc_pkg::OSC_NUM))
            rdata_nxt = 32'(osc_cnt_r[2'(ps_addr_i - tsc_pkg::REG_OSC_COUNT0)]);
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ps_rdata_o  <= tsc_pkg::ZERO_WORD;
            ps_rvalid_o <= 1'b0;
        end
        else
        begin
            ps_rvalid_o <= ps_read_i;
            if (ps_read_i)
                ps_rdata_o <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_ctrl_write;
        wr_ctrl |=> ethernet_port_enable_o == $past(ps_wdata_i[tsc_pkg::ETH_EN_BIT])
            && usb_phy_interface_select_o == $past(ps_wdata_i[tsc_pkg::USB_SEL_BIT]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("Control write did not reach the port enables.");

    property p_ctrl_reserved;
        ps_read_i && ps_addr_i == tsc_pkg::REG_TILE_CTRL
            |=> (ps_rdata_o & ~tsc_pkg::CTRL_WMASK) == tsc_pkg::ZERO_WORD;
    endproperty
    a_ctrl_reserved: assert property (p_ctrl_reserved)
        else $error("Reserved control bits read nonzero.");

    property p_prot_locked;
        prot_r[tsc_pkg::PROT_LOCK_BIT] && !otp_load_i |=> $stable(prot_r);
    endproperty
    a_prot_locked: assert property (p_prot_locked)
        else $error("Locked protection register changed.");

    property p_otp_load;
        otp_load_i |=> prot_r == ($past(otp_security_word_i) & tsc_pkg::PROT_WMASK)
            ##1 (jtag_tap_block_o == prot_r[tsc_pkg::PROT_TAP_BIT]);
    endproperty
    a_otp_load: assert property (p_otp_load)
        else $error("OTP copy not loaded into protection register.");

    property p_lp_static;
        ctrl_r[tsc_pkg::LP_EN_BIT] && !ctrl_r[tsc_pkg::LP_DYN_BIT] [*2] |-> lp_div_active_o;
    endproperty
    a_lp_static: assert property (p_lp_static)
        else $error("Static low-power divider not active.");

    property p_lp_dynamic;
        ctrl_r[tsc_pkg::LP_DYN_BIT] && !threads_paused_i |=> !lp_div_active_o;
    endproperty
    a_lp_dynamic: assert property (p_lp_dynamic)
        else $error("Dynamic divider active while a thread runs.");

    property p_osc_hold;
        !osc_run[0] |=> osc_cnt_r[0] == $past(osc_cnt_r[0]);
    endproperty
    a_osc_hold: assert property (p_osc_hold)
        else $error("Stopped oscillator counter moved.");

    property p_count_read;
        ps_read_i && ps_addr_i == tsc_pkg::REG_OSC_COUNT0
            |=> ps_rvalid_o && ps_rdata_o[31:16] == 16'h0000;
    endproperty
    a_count_read: assert property (p_count_read)
        else $error("Counter read has upper bits set or no answer.");

    property p_strap_read;
        ps_read_i && ps_addr_i == tsc_pkg::REG_BOOT_STATUS
            |=> ps_rdata_o[1:0] == $past(strap_r) && ps_rdata_o[23:16] == $past(processor_number_i);
    endproperty
    a_strap_read: assert property (p_strap_read)
        else $error("Boot status read does not match straps or number.");

    c_prot_refused: cover property (prot_r[tsc_pkg::PROT_LOCK_BIT] && wr_prot);
    c_lp_dyn: cover property (ctrl_r[tsc_pkg::LP_DYN_BIT] && lp_div_active_o);
    c_osc_count: cover property (osc_run[0] ##1 $changed(osc_cnt_r[0]));

endmodule // tsc_status_regs

// file: tsc_pkg.sv
package tsc_pkg;

    // Register numbers used by the status read and write instructions.
    localparam logic [7:0]  REG_TILE_CTRL      = 8'h02;
    localparam logic [7:0]  REG_BOOT_STATUS    = 8'h03;
    localparam logic [7:0]  REG_PROTECTION     = 8'h05;
    localparam logic [7:0]  REG_OSC_RUN        = 8'h06;
    localparam logic [7:0]  REG_OSC_COUNT0     = 8'h07;

    localparam int          OSC_NUM            = 4;
    localparam int          OSC_COUNT_W        = 16;

    // Tile control fields.
    localparam int          TXD_DLY_LSB        = 18;
    localparam int          TXD_DLY_W          = 8;
    localparam int          TXCLK_DIV_LSB      = 9;
    localparam int          TXCLK_DIV_W        = 9;
    localparam int          ETH_EN_BIT         = 8;
    localparam int          LP_DYN_BIT         = 5;
    localparam int          LP_EN_BIT          = 4;
    localparam int          USB_SEL_BIT        = 2;
    localparam int          USB_SUP_BIT        = 1;
    localparam logic [31:0] CTRL_WMASK         = 32'h03FF_FF36;
    localparam logic [31:0] CTRL_RESET         = 32'h0000_0000;

    // Boot status fields.
    localparam int          PROC_NUM_LSB       = 16;
    localparam int          BOOT_OVERRIDE_BIT  = 8;
    localparam int          CORE_OFF_BIT       = 5;
    localparam int          SKIP_POLL_BIT      = 4;
    localparam int          BOOT_RAM_BIT       = 3;
    localparam int          BOOT_JTAG_BIT      = 2;
    localparam int          STRAP_LSB          = 0;
    localparam int          STRAP_W            = 2;

    // Protection settings fields.
    localparam int          PROT_LOCK_BIT      = 31;
    localparam int          PROT_GDBG_BIT      = 14;
    localparam int          PROT_MASTER_BIT    = 12;
    localparam int          PROT_SECTOR_LSB    = 8;
    localparam int          PROT_SECTOR_W      = 4;
    localparam int          PROT_REDUND_BIT    = 7;
    localparam int          PROT_BOOT_OTP_BIT  = 5;
    localparam int          PROT_PLL_JTAG_BIT  = 4;
    localparam int          PROT_TAP_BIT       = 0;
    localparam logic [31:0] PROT_WMASK         = 32'h8000_5FB1;
    localparam logic [31:0] PROT_RESET         = 32'h0000_0000;

    // Oscillator run control fields.
    localparam int          OSC_CORE_BIT       = 1;
    localparam int          OSC_PERIPH_BIT     = 0;
    localparam logic [31:0] OSC_RUN_WMASK      = 32'h0000_0003;
    localparam logic [1:0]  OSC_RUN_RESET      = 2'h0;

    localparam logic [31:0] ZERO_WORD          = 32'h0000_0000;

endpackage

// file: tsc_txclk_gen.sv
`timescale 1ns/1ns
module tsc_txclk_gen
#(
    parameter int DIV_W = 9,
    parameter int DLY_W = 8
)
(
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             enable_i,
    input  wire logic [DIV_W-1:0] div_i,
    input  wire logic [DLY_W-1:0] delay_i,
    output logic                  tx_clk_o,
    output logic                  tx_launch_o
);

    logic [DIV_W-1:0] cnt_r;
    logic [DLY_W-1:0] dly_r;
    logic             dly_busy_r;
    logic             rise_evt;

    assign rise_evt = enable_i && (cnt_r == div_i);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            cnt_r <= '0;
        else if (!enable_i || rise_evt)
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + 1'b1;
    end

    // A programmed value of zero leaves the clock high: the divider cannot
    // go faster than its own input clock.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            tx_clk_o <= 1'b0;
        else if (!enable_i)
            tx_clk_o <= 1'b0;
        else if (rise_evt)
            tx_clk_o <= 1'b1;
        else if (cnt_r == (div_i >> 1))
            tx_clk_o <= 1'b0;
    end

    // Launch strobe trails the clock rise by the programmed count.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            dly_r       <= '0;
            dly_busy_r  <= 1'b0;
            tx_launch_o <= 1'b0;
        end
        else if (rise_evt)
        begin
            dly_r       <= delay_i;
            dly_busy_r  <= (delay_i != '0);
            tx_launch_o <= (delay_i == '0);
        end
        else if (dly_busy_r && enable_i)
        begin
            dly_r       <= dly_r - 1'b1;
            dly_busy_r  <= (dly_r != 1);
            tx_launch_o <= (dly_r == 1);
        end
        else
        begin
            dly_busy_r  <= 1'b0;
            tx_launch_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_txclk_rise;
        @(posedge clk_i) disable iff (!reset_n_i)
        rise_evt |=> tx_clk_o ##1 (tx_clk_o || (div_i < 2));
    endproperty
    a_txclk_rise: assert property (p_txclk_rise)
        else $error("Transmit clock did not rise at the divider terminal count.");

    property p_launch_delay;
        @(posedge clk_i) disable iff (!reset_n_i)
        rise_evt && delay_i == 2 && div_i > 2 ##1 enable_i [*2] |=> tx_launch_o;
    endproperty
    a_launch_delay: assert property (p_launch_delay)
        else $error("Launch strobe not at the programmed delay.");

    c_launch: cover property (@(posedge clk_i) disable iff (!reset_n_i)
        rise_evt ##[1:20] tx_launch_o);

endmodule // tsc_txclk_gen

// file: tsc_status_regs_test.sv
`timescale 1ns/1ns
module tsc_status_regs_test;
    logic        clk_i;
    logic        reset_n_i;
    logic        ps_write_i;
    logic        ps_read_i;
    logic [7:0]  ps_addr_i;
    logic [31:0] ps_wdata_i;
    logic [31:0] ps_rdata_o;
    logic        ps_rvalid_o;
    logic        threads_paused_i;
    logic [7:0]  proc_num;
    logic [3:0]  boot_bits;
    logic [1:0]  strap;
    logic        otp_load_i;
    logic [31:0] otp_word;
    logic [3:0]  osc_i;
    logic        eth_en;
    logic        tx_clk;
    logic        tx_launch;
    logic        lp_active;
    logic        usb_sel;
    logic        usb_sup;
    logic [9:0]  prot_out;
    logic [3:0]  osc_run_o;
    logic [31:0] rd_word;
    logic [15:0] c0 [4];
    logic [15:0] c1 [4];
    int          fail_count;
    int          num_checks;

    tsc_status_regs i_dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .ps_write_i(ps_write_i),
        .ps_read_i(ps_read_i), .ps_addr_i(ps_addr_i), .ps_wdata_i(ps_wdata_i),
        .ps_rdata_o(ps_rdata_o), .ps_rvalid_o(ps_rvalid_o),
        .threads_paused_i(threads_paused_i), .processor_number_i(proc_num),
        .second_core_powered_flag_i(boot_bits[3]), .skip_otp_level_poll_i(boot_bits[2]),
        .boot_from_ram_i(boot_bits[1]), .boot_from_jtag_i(boot_bits[0]),
        .pll_strap_value_i(strap), .otp_load_i(otp_load_i),
        .otp_security_word_i(otp_word), .osc_i(osc_i),
        .ethernet_port_enable_o(eth_en), .rgmii_tx_clk_o(tx_clk),
        .rgmii_tx_launch_o(tx_launch), .lp_div_active_o(lp_active),
        .usb_phy_interface_select_o(usb_sel), .transceiver_support_enable_o(usb_sup),
        .global_debug_block_o(prot_out[9]), .otp_master_lock_o(prot_out[8]),
        .otp_sector_lock_o(prot_out[7:4]), .otp_redundancy_en_o(prot_out[3]),
        .otp_boot_override_o(prot_out[2]), .pll_jtag_block_o(prot_out[1]),
        .jtag_tap_block_o(prot_out[0]), .osc_run_o(osc_run_o)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Ring oscillators are free running and unrelated in phase to the tile clock.
    initial
    begin
        osc_i = 4'h0;
        #7;
        forever #130 osc_i = ~osc_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ps_write_i = 1'b1;
        ps_addr_i  = a;
        ps_wdata_i = d;
        step(1);
        ps_write_i = 1'b0;
        step(1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        ps_read_i = 1'b1;
        ps_addr_i = a;
        step(1);
        chk("read valid", 32'h0000_0001, {31'h0, ps_rvalid_o});
        d         = ps_rdata_o;
        ps_read_i = 1'b0;
        // An idle cycle keeps back-to-back calls from toggling the strobe in one step.
        step(1);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(nm, exp, d);
    endtask

    task automatic do_reset();
        reset_n_i = 1'b0;
        step(3);
        reset_n_i = 1'b1;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #100000;
        fail_count++;
        give_verdict();
    end

    initial
    begin
        int r;
        int l;
        int hi;
        logic p;
        {ps_write_i, ps_read_i, otp_load_i, threads_paused_i} = 4'h0;
        ps_addr_i = 8'h00;
        ps_wdata_i = 32'h0000_0000;
        otp_word = 32'h0000_0000;
        proc_num = 8'hA5;
        boot_bits = 4'b1010;
        strap = 2'b10;
        reset_n_i = 1'b0;
        step(3);
        reset_n_i = 1'b1;
        rdchk("ctrl reset", tsc_pkg::REG_TILE_CTRL, 32'h0000_0000);
        rdchk("osc run reset", tsc_pkg::REG_OSC_RUN, 32'h0000_0000);
        rdchk("unmapped 04", 8'h04, 32'h0000_0000);
        rdchk("unmapped 0B", 8'h0B, 32'h0000_0000);
        $display("test reset done");

        wr(tsc_pkg::REG_TILE_CTRL, 32'hFFFF_FFFF);
        rdchk("ctrl all ones", tsc_pkg::REG_TILE_CTRL, 32'h03FF_FF36);
        chk("eth usb", 32'h0000_0007, {29'h0, eth_en, usb_sel, usb_sup});
        step(2);
        chk("lp dyn busy", 32'h0000_0000, {31'h0, lp_active});
        threads_paused_i = 1'b1;
        step(2);
        chk("lp dyn paused", 32'h0000_0001, {31'h0, lp_active});
        threads_paused_i = 1'b0;
        wr(tsc_pkg::REG_TILE_CTRL, 32'h0000_0010);
        step(2);
        chk("lp static", 32'h0000_0001, {31'h0, lp_active});
        chk("eth usb off", 32'h0000_0000, {29'h0, eth_en, usb_sel, usb_sup});
        for (int dl = 0; dl <= 2; dl += 2)
        begin
            // Divider value 3 gives a four cycle period, high for two cycles.
            wr(tsc_pkg::REG_TILE_CTRL, (32'(dl) << 18) | 32'h0000_0700);
            rdchk("ctrl tx", tsc_pkg::REG_TILE_CTRL, (32'(dl) << 18) | 32'h0000_0700);
            step(4);
            r = -1;
            l = -1;
            hi = 0;
            p = tx_clk;
            for (int i = 0; i < 24; i++)
            begin
                step(1);
                hi += int'(tx_clk === 1'b1);
                if (r < 0 && tx_clk === 1'b1 && p === 1'b0)
                    r = i;
                if (r >= 0 && l < 0 && tx_launch === 1'b1)
                    l = i;
                p = tx_clk;
            end
            chk("tx clk high", 32'd12, 32'(hi));
            chk("tx launch delay", 32'(dl), 32'(l - r));
        end
        $display("test tile control done");

        step(6);
        rdchk("boot a", tsc_pkg::REG_BOOT_STATUS, 32'h00A5_002A);
        proc_num = 8'h3C;
        boot_bits = 4'b0101;
        strap = 2'b01;
        wr(tsc_pkg::REG_BOOT_STATUS, 32'hFFFF_FFFF);
        step(6);
        rdchk("boot b", tsc_pkg::REG_BOOT_STATUS, 32'h003C_0015);
        $display("test boot status done");

        wr(tsc_pkg::REG_OSC_RUN, 32'hFFFF_FFFF);
        rdchk("osc run", tsc_pkg::REG_OSC_RUN, 32'h0000_0003);
        chk("osc run out", 32'h0000_000F, {28'h0, osc_run_o});
        step(50);
        wr(tsc_pkg::REG_OSC_RUN, 32'h0000_0000);
        step(12);
        for (int k = 0; k < 4; k++)
        begin
            rd(tsc_pkg::REG_OSC_COUNT0 + 8'(k), rd_word);
            chk("osc high zero", 32'h0000_0000, {16'h0, rd_word[31:16]});
            c0[k] = rd_word[15:0];
        end
        wr(tsc_pkg::REG_OSC_RUN, 32'h0000_0002);
        chk("osc core out", 32'h0000_0003, {28'h0, osc_run_o});
        step(52);
        wr(tsc_pkg::REG_OSC_RUN, 32'h0000_0000);
        step(12);
        for (int k = 0; k < 4; k++)
        begin
            rd(tsc_pkg::REG_OSC_COUNT0 + 8'(k), rd_word);
            c1[k] = rd_word[15:0];
            if (k < 2)
                chk("osc core delta", 32'h1, 32'((c1[k] - c0[k]) inside {[9:11]}));
            else
                chk("osc periph hold", 32'(c0[k]), 32'(c1[k]));
        end
        wr(tsc_pkg::REG_OSC_RUN, 32'h0000_0001);
        chk("osc periph out", 32'h0000_000C, {28'h0, osc_run_o});
        wr(tsc_pkg::REG_OSC_RUN, 32'h0000_0000);
        step(12);
        // The peripheral pair may have counted during its short run, so take fresh values.
        for (int k = 0; k < 4; k++)
        begin
            rd(tsc_pkg::REG_OSC_COUNT0 + 8'(k), rd_word);
            c1[k] = rd_word[15:0];
        end
        $display("test oscillators done");

        otp_load_i = 1'b1;
        otp_word = 32'hFFFF_FFFF;
        step(1);
        otp_load_i = 1'b0;
        rdchk("prot otp", tsc_pkg::REG_PROTECTION, 32'h8000_5FB1);
        chk("prot outs all", 32'h0000_03FF, {22'h0, prot_out});
        wr(tsc_pkg::REG_PROTECTION, 32'h0000_0000);
        rdchk("prot locked", tsc_pkg::REG_PROTECTION, 32'h8000_5FB1);
        do_reset();
        rdchk("prot reset", tsc_pkg::REG_PROTECTION, 32'h0000_0000);
        for (int k = 0; k < 4; k++)
            rdchk("osc kept", tsc_pkg::REG_OSC_COUNT0 + 8'(k), {16'h0, c1[k]});
        wr(tsc_pkg::REG_PROTECTION, 32'h0000_4A20);
        rdchk("prot write", tsc_pkg::REG_PROTECTION, 32'h0000_4A20);
        chk("prot outs", 32'h0000_02A4, {22'h0, prot_out});
        rdchk("boot override", tsc_pkg::REG_BOOT_STATUS, 32'h003C_0115);
        $display("test protection done");
        give_verdict();
    end
endmodule // tsc_status_regs_test
